// ==== hdl/fla_regs.sv ====
// Fault log and converter control register bank of a dual-channel supply
// insertion controller. Assumes a serial-bus slave outside that presents
// one-cycle read and write strobes with an 8-bit register address, and an
// analog converter that answers each start with one done pulse.
//
// Overview of operation
// - Fault logs per channel at d3 and d7
// - Bit 5: current sense while transistor off
// - Bit 4: card enable pin changed state
// - Bit 3: output feedback went low
// - Bit 2: overcurrent fault occurred
// - Bit 1: undervoltage input went low
// - Bit 0: overvoltage input went high
// - Fault bits 7 and 6 reserved
// - High byte holds result bits 9..2
// - Low byte bits 7,6 hold result 1,0
// - Control register at e4, bits 7,6 reserved
// - Busy bit reflects converting or free-running
// - Alert enable pulls alert low on completion
// - Channel address writable only while stopped
// - Address write runs one measurement, then stops
// - Stop bit halts free-run, enables single-shot
// - Fault alerts gated by per-channel enables
`timescale 1ns/10ps
`include "fla_params.svh"

module fla_regs #(
    parameter int NUM_INPUTS = `FLA_NUM_INPUTS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port from the serial-bus slave
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // Fault pins per channel
    input wire fla_pkg::fla_pins_s pins_ch1,
    input wire fla_pkg::fla_pins_s pins_ch2,
    // Per-channel alert enables held outside
    input wire logic [5:0] alert_en_ch1,
    input wire logic [5:0] alert_en_ch2,
    // Converter alert acknowledge from the serial-bus slave
    input wire logic alert_ack,
    // Converter
    output fla_pkg::fla_conv_req_s conv_req,
    input wire fla_pkg::fla_conv_rsp_s conv_rsp,
    // Alert pin, open drain: only ever pulled low
    output logic alert_o,
    output logic alert_oe
);

    localparam int RB = `FLA_RESULT_BITS;

    // ========================================================
    // Address decode
    logic wr_flt1, wr_flt2, wr_ctl;
    logic [NUM_INPUTS-1:0] wr_hi, wr_lo;

    always_comb begin
        wr_flt1 = reg_wr && (reg_addr == `FLA_OFF_FAULT_CH1);
        wr_flt2 = reg_wr && (reg_addr == `FLA_OFF_FAULT_CH2);
        wr_ctl = reg_wr && (reg_addr == `FLA_OFF_CONV_CTRL);
        for (int i = 0; i < NUM_INPUTS; i++) begin
            wr_hi[i] = reg_wr && (reg_addr == `FLA_OFF_RESULT_BASE + 8'(2 * i));
            wr_lo[i] = reg_wr && (reg_addr == `FLA_OFF_RESULT_BASE + 8'(2 * i + 1));
        end
    end

    // ========================================================
    // Fault logs
    logic [5:0] fault_ch1, fault_ch2;

    fla_fault_chan u_fault_ch1 (
        .clk(clk),
        .rst(rst),
        .pins(pins_ch1),
        .wr_en(wr_flt1),
        .wdata(reg_wdata),
        .fault_q(fault_ch1)
    );

    fla_fault_chan u_fault_ch2 (
        .clk(clk),
        .rst(rst),
        .pins(pins_ch2),
        .wr_en(wr_flt2),
        .wdata(reg_wdata),
        .fault_q(fault_ch2)
    );

    // ========================================================
    // Converter control
    fla_pkg::fla_cv_e cv_q, cv_d;
    logic halt_q, halt_d;
    logic adc_alert_en_q, adc_alert_en_d;
    logic [2:0] chan_q, chan_d;
    logic [2:0] cur_q, cur_d;
    logic start_q, start_d;
    logic adc_alert_q, adc_alert_d;

    always_comb begin
        cv_d = cv_q;
        halt_d = halt_q;
        adc_alert_en_d = adc_alert_en_q;
        chan_d = chan_q;
        cur_d = cur_q;
        start_d = 1'b0;
        adc_alert_d = adc_alert_q;
        if (wr_ctl) begin
            adc_alert_en_d = reg_wdata[`FLA_CTL_ALERT_EN];
            halt_d = reg_wdata[`FLA_CTL_HALT];
        end
        unique case (cv_q)
            fla_pkg::FLA_CV_FREE: begin
                if (wr_ctl && reg_wdata[`FLA_CTL_HALT]) begin
                    // A conversion in flight is abandoned, its result dropped
                    cv_d = fla_pkg::FLA_CV_HALTED;
                end else if (conv_rsp.done) begin
                    cur_d = (cur_q == 3'(NUM_INPUTS - 1)) ? 3'h0 : cur_q + 3'h1;
                    start_d = 1'b1;
                end
            end
            fla_pkg::FLA_CV_SINGLE: begin
                if (conv_rsp.done) begin
                    cv_d = fla_pkg::FLA_CV_HALTED;
                end
            end
            fla_pkg::FLA_CV_HALTED: begin
                if (wr_ctl && !reg_wdata[`FLA_CTL_HALT]) begin
                    cv_d = fla_pkg::FLA_CV_FREE;
                    cur_d = 3'h0;
                    start_d = 1'b1;
                end else if (wr_ctl && halt_q) begin
                    // Address accepted only while already stopped
                    chan_d = reg_wdata[`FLA_CTL_CHAN_HI:`FLA_CTL_CHAN_LO];
                    cur_d = chan_d;
                    cv_d = fla_pkg::FLA_CV_SINGLE;
                    start_d = 1'b1;
                end
            end
            default: begin
                cv_d = fla_pkg::FLA_CV_HALTED;
            end
        endcase
        // Completion alert; a new completion beats the acknowledge
        if (alert_ack) begin
            adc_alert_d = 1'b0;
        end
        if (conv_rsp.done && cv_q != fla_pkg::FLA_CV_HALTED && adc_alert_en_q) begin
            adc_alert_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cv_q <= fla_pkg::FLA_CV_FREE;
            halt_q <= `FLA_CTL_HALT_RESET;
            adc_alert_en_q <= `FLA_CTL_ALERT_RESET;
            chan_q <= `FLA_CTL_CHAN_RESET;
            cur_q <= 3'h0;
            start_q <= 1'b0;
            adc_alert_q <= 1'b0;
        end else begin
            cv_q <= cv_d;
            halt_q <= halt_d;
            adc_alert_en_q <= adc_alert_en_d;
            chan_q <= chan_d;
            cur_q <= cur_d;
            start_q <= start_d;
            adc_alert_q <= adc_alert_d;
        end
    end

    // Out of reset the halt bit is clear, so free-running must be kicked off
    logic boot_q, boot_d;

    always_comb begin
        boot_d = 1'b0;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            boot_q <= 1'b1;
        end else begin
            boot_q <= boot_d;
        end
    end

    // ========================================================
    // Converter results
    logic [RB-1:0] result_q [NUM_INPUTS];
    logic [RB-1:0] result_d [NUM_INPUTS];

    always_comb begin
        for (int i = 0; i < NUM_INPUTS; i++) begin
            result_d[i] = result_q[i];
            if (conv_rsp.done && cv_q != fla_pkg::FLA_CV_HALTED && cur_q == 3'(i)) begin
                result_d[i] = conv_rsp.data;
            end
            // Host writes assume the converter is stopped
            if (wr_hi[i]) begin
                result_d[i][RB-1:2] = reg_wdata;
            end
            if (wr_lo[i]) begin
                result_d[i][1:0] = reg_wdata[7:6];
            end
        end
    end

    always_ff @(posedge clk) begin
        for (int i = 0; i < NUM_INPUTS; i++) begin
            if (rst) begin
                result_q[i] <= `FLA_RESULT_RESET;
            end else begin
                result_q[i] <= result_d[i];
            end
        end
    end

    // ========================================================
    // Read path
    logic [7:0] rd_val;
    logic [7:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;
    logic busy;

    always_comb begin
        busy = (cv_q != fla_pkg::FLA_CV_HALTED);
        rd_val = 8'h00;
        if (reg_addr == `FLA_OFF_FAULT_CH1) begin
            rd_val = {2'h0, fault_ch1};
        end else if (reg_addr == `FLA_OFF_FAULT_CH2) begin
            rd_val = {2'h0, fault_ch2};
        end else if (reg_addr == `FLA_OFF_CONV_CTRL) begin
            rd_val = {2'h0, busy, adc_alert_en_q, chan_q, halt_q};
        end else begin
            for (int i = 0; i < NUM_INPUTS; i++) begin
                if (reg_addr == `FLA_OFF_RESULT_BASE + 8'(2 * i)) begin
                    rd_val = result_q[i][RB-1:2];
                end
                if (reg_addr == `FLA_OFF_RESULT_BASE + 8'(2 * i + 1)) begin
                    rd_val = {result_q[i][1:0], 6'h00};
                end
            end
        end
        rdata_d = reg_rd ? rd_val : rdata_q;
        rvalid_d = reg_rd;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // ========================================================
    // Alert and converter outputs
    logic alert_q, alert_d;

    always_comb begin
        alert_d = |(fault_ch1 & alert_en_ch1) | |(fault_ch2 & alert_en_ch2)
            | adc_alert_q;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            alert_q <= 1'b0;
        end else begin
            alert_q <= alert_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;
    assign alert_o = 1'b0;
    assign alert_oe = alert_q;
    assign conv_req.start = start_q | (boot_q & ~rst);
    assign conv_req.chan = cur_q;

endmodule // fla_regs

// ==== hdl/fla_params.svh ====
// Offsets, field positions and reset values of the fault log and converter
// control register bank. Included by the package and the design files.
`ifndef FLA_PARAMS_SVH
`define FLA_PARAMS_SVH

// Register offsets
`define FLA_OFF_FAULT_CH1 8'hd3
`define FLA_OFF_FAULT_CH2 8'hd7
`define FLA_OFF_CONV_CTRL 8'he4
`define FLA_OFF_RESULT_BASE 8'hd8

// Fault log fields
`define FLA_FLT_FET_SHORT 5
`define FLA_FLT_EN_CHANGE 4
`define FLA_FLT_POWER_BAD 3
`define FLA_FLT_OVERCURRENT 2
`define FLA_FLT_UNDERVOLT 1
`define FLA_FLT_OVERVOLT 0
`define FLA_FLT_USED_MASK 8'h3f
`define FLA_FLT_RESET 6'h00

// Converter control fields
`define FLA_CTL_BUSY 5
`define FLA_CTL_ALERT_EN 4
`define FLA_CTL_CHAN_HI 3
`define FLA_CTL_CHAN_LO 1
`define FLA_CTL_HALT 0
`define FLA_CTL_HALT_RESET 1'b0
`define FLA_CTL_ALERT_RESET 1'b0
`define FLA_CTL_CHAN_RESET 3'h0

// Converter inputs and result layout
`define FLA_NUM_INPUTS 6
`define FLA_RESULT_BITS 10
`define FLA_RESULT_RESET 10'h000

// Pin synchroniser depth and settling time after reset
`define FLA_SYNC_STAGES 3
`define FLA_PRIME_CYCLES 3'h5

`endif

// ==== hdl/fla_pkg.sv ====
// Types shared by the fault log and converter control register bank.
// Assumes fla_params.svh is on the include path.
`include "fla_params.svh"

package fla_pkg;

    // Raw per-channel fault sources, all asynchronous to clk
    typedef struct packed {
        logic fet_cmd_on;
        logic sense_over_1mv;
        logic card_enable_n;
        logic output_feedback_input;
        logic overcurrent;
        logic undervoltage_input;
        logic overvoltage_input;
    } fla_pins_s;

    typedef enum logic [2:0] {
        FLA_SEL_OUT_V1 = 3'h0,
        FLA_SEL_OUT_V2 = 3'h1,
        FLA_SEL_AUX1 = 3'h2,
        FLA_SEL_AUX2 = 3'h3,
        FLA_SEL_SENSE1 = 3'h4,
        FLA_SEL_SENSE2 = 3'h5
    } fla_sel_e;

    typedef enum logic [1:0] {
        FLA_CV_HALTED = 2'h0,
        FLA_CV_FREE = 2'h1,
        FLA_CV_SINGLE = 2'h2
    } fla_cv_e;

    // Converter request towards the analog converter
    typedef struct packed {
        logic start;
        logic [2:0] chan;
    } fla_conv_req_s;

    // Converter answer: one-cycle done with the result of the started input
    typedef struct packed {
        logic done;
        logic [`FLA_RESULT_BITS-1:0] data;
    } fla_conv_rsp_s;

endpackage : fla_pkg

// ==== hdl/fla_fault_chan.sv ====
// One channel's fault log: pin synchronisers, event detection, sticky bits.
// Assumes a host write port decoded by the parent and pins async to clk.
`timescale 1ns/10ps
`include "fla_params.svh"

module fla_fault_chan (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Pins of this channel
    input wire fla_pkg::fla_pins_s pins,
    // Host write of this channel's fault log
    input wire logic wr_en,
    input wire logic [7:0] wdata,
    // Sticky fault bits
    output logic [5:0] fault_q
);

    localparam int NP = $bits(fla_pkg::fla_pins_s);

    // ========================================================
    // Pin synchronisers
    logic [NP-1:0] s1_q, s2_q, s3_q, filt_q, filt_d, prev_q;
    // Priming covers the stages and the filter plus one history stage,
    // so the first compare never sees a reset zero as an old pin level
    logic [2:0] prime_q, prime_d;
    fla_pkg::fla_pins_s cur, old;
    logic [5:0] set, fault_d;

    always_comb begin
        filt_d = filt_q;
        // A change counts only once the last two stages agree
        for (int i = 0; i < NP; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                filt_d[i] = s3_q[i];
            end
        end
        prime_d = (prime_q == `FLA_PRIME_CYCLES) ? prime_q : prime_q + 3'h1;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            filt_q <= '0;
            prev_q <= '0;
            prime_q <= 3'h0;
        end else begin
            s1_q <= pins;
            s2_q <= s1_q;
            s3_q <= s2_q;
            filt_q <= filt_d;
            prev_q <= filt_q;
            prime_q <= prime_d;
        end
    end

    // ========================================================
    // Event detection and sticky log
    always_comb begin
        cur = filt_q;
        old = prev_q;
        set = 6'h00;
        // Edges are meaningless until the synchronisers have filled
        if (prime_q == `FLA_PRIME_CYCLES) begin
            set[`FLA_FLT_FET_SHORT] = cur.sense_over_1mv & ~cur.fet_cmd_on;
            set[`FLA_FLT_EN_CHANGE] = cur.card_enable_n ^ old.card_enable_n;
            set[`FLA_FLT_POWER_BAD] = ~cur.output_feedback_input
                & old.output_feedback_input;
            set[`FLA_FLT_OVERCURRENT] = cur.overcurrent & ~old.overcurrent;
            set[`FLA_FLT_UNDERVOLT] = ~cur.undervoltage_input
                & old.undervoltage_input;
            set[`FLA_FLT_OVERVOLT] = cur.overvoltage_input
                & ~old.overvoltage_input;
        end
        // Bits hold until the host writes zero; a new event beats the clear
        fault_d = (wr_en ? wdata[5:0] : fault_q) | set;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            fault_q <= `FLA_FLT_RESET;
        end else begin
            fault_q <= fault_d;
        end
    end

endmodule // fla_fault_chan

// ==== sim/fla_regs_assertions.sv ====
// Port-level checks for the fault log and converter control bank.
// Assumes the bind at the foot attaches it to every fla_regs instance.
`timescale 1ns/10ps

module fla_regs_chk #(
    parameter int NUM_INPUTS = 6
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    // Alerts and converter
    input wire logic [5:0] alert_en_ch1,
    input wire logic [5:0] alert_en_ch2,
    input wire fla_pkg::fla_conv_req_s conv_req,
    input wire fla_pkg::fla_conv_rsp_s conv_rsp,
    input wire logic alert_o,
    input wire logic alert_oe
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (rst);

    // ==========================================================
    // Mirrors of halt, converter alert enable and a pending shot
    logic ctl_wr;
    logic halt_q, halt_d, aen_q, aen_d, pend_q, pend_d;
    assign ctl_wr = reg_wr && reg_addr == 8'he4;

    always_comb begin
        halt_d = halt_q;
        aen_d = aen_q;
        pend_d = pend_q;
        if (conv_rsp.done) pend_d = 1'b0;
        if (conv_req.start && halt_q) pend_d = 1'b1;
        if (ctl_wr) begin
            halt_d = reg_wdata[0];
            aen_d = reg_wdata[4];
            if (!reg_wdata[0]) pend_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            halt_q <= 1'b0;
            aen_q <= 1'b0;
            pend_q <= 1'b0;
        end else begin
            halt_q <= halt_d;
            aen_q <= aen_d;
            pend_q <= pend_d;
        end
    end

    // ==========================================================
    // Assertions
    chk_read_answer: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered after one cycle");
    chk_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd))
        else $error("read valid without a read");
    chk_rdata_hold: assert property (!reg_rvalid |-> $stable(reg_rdata))
        else $error("read data moved without a read");
    chk_reserved_zero: assert property (reg_rd && (reg_addr == 8'hd3 ||
        reg_addr == 8'hd7 || reg_addr == 8'he4) |=> reg_rdata[7:6] == 2'b00)
        else $error("reserved bits read nonzero");
    chk_unmapped_zero: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata == 8'h00)
        else $error("unmapped address read nonzero");
    chk_alert_value: assert property (alert_o == 1'b0)
        else $error("alert pin driven high");
    chk_alert_cause: assert property (alert_oe |-> $past(alert_en_ch1) != 6'h00 ||
        $past(alert_en_ch2) != 6'h00 || $past(aen_q))
        else $error("alert without any enable");
    chk_conv_alert: assert property (conv_rsp.done && pend_q && aen_q |-> ##[1:2] alert_oe)
        else $error("no alert after measurement");
    chk_start_pulse: assert property (conv_req.start |=> !conv_req.start)
        else $error("start longer than one cycle");
    chk_freerun_step: assert property (conv_rsp.done && !halt_q && !ctl_wr |=>
        conv_req.start && conv_req.chan == (($past(conv_req.chan) == 3'(NUM_INPUTS - 1))
        ? 3'h0 : $past(conv_req.chan) + 3'h1))
        else $error("free run did not step to next input");
    chk_single_start: assert property (ctl_wr && reg_wdata[0] && halt_q && !pend_q
        |=> conv_req.start && conv_req.chan == $past(reg_wdata[3:1]))
        else $error("single shot not started on written input");

    cover property (conv_rsp.done && !halt_q);
    cover property (conv_req.start && halt_q);
    cover property (alert_oe && !aen_q);
endmodule // fla_regs_chk

bind fla_regs fla_regs_chk #(.NUM_INPUTS(NUM_INPUTS)) i_chk (
    .clk, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid,
    .alert_en_ch1, .alert_en_ch2, .conv_req, .conv_rsp, .alert_o, .alert_oe
);

// ==== sim/fla_conv_model.sv ====
// Behavioural analog converter answering each start with one done pulse.
// Assumes start is a one-cycle pulse; a new start abandons the old one.
`timescale 1ns/10ps

module fla_conv_model #(
    parameter int LAT = 6
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Converter handshake
    input wire fla_pkg::fla_conv_req_s conv_req,
    output fla_pkg::fla_conv_rsp_s conv_rsp
);
    logic [2:0] chan_q = 3'h0;
    int cnt_q = 0;

    // ==========================================================
    // Data is only meaningful with done, so it toggles otherwise
    always @(posedge clk) begin
        conv_rsp.done <= 1'b0;
        conv_rsp.data <= ~conv_rsp.data;
        if (rst) begin
            conv_rsp.data <= '0;
            cnt_q <= 0;
        end else if (conv_req.start) begin
            chan_q <= conv_req.chan;
            cnt_q <= LAT;
        end else if (cnt_q == 1) begin
            conv_rsp.done <= 1'b1;
            conv_rsp.data <= {chan_q, chan_q, chan_q, 1'b1};
            cnt_q <= 0;
        end else if (cnt_q > 1) begin
            cnt_q <= cnt_q - 1;
        end
    end
endmodule // fla_conv_model

// ==== sim/fla_regs_test.sv ====
// Self-checking bench for the fault log and converter control bank.
// Assumes fla_pkg is compiled first and the converter model is present.
`timescale 1ns/10ps

module fla_regs_test;
    localparam int LAT = 6;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    fla_pkg::fla_pins_s pins_ch1 = 7'h5a;
    fla_pkg::fla_pins_s pins_ch2 = 7'h5a;
    logic [5:0] alert_en_ch1 = 6'h00;
    logic [5:0] alert_en_ch2 = 6'h00;
    logic alert_ack = 1'b0;
    fla_pkg::fla_conv_req_s conv_req;
    fla_pkg::fla_conv_rsp_s conv_rsp;
    logic alert_o;
    logic alert_oe;
    int error_cnt = 0;
    int check_count = 0;
    int cycles = 0;
    logic [9:0] d;
    logic [6:0] flip;
    logic [7:0] a;

    fla_regs i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .pins_ch1(pins_ch1), .pins_ch2(pins_ch2),
        .alert_en_ch1(alert_en_ch1), .alert_en_ch2(alert_en_ch2),
        .alert_ack(alert_ack), .conv_req(conv_req), .conv_rsp(conv_rsp),
        .alert_o(alert_o), .alert_oe(alert_oe));
    fla_conv_model #(.LAT(LAT)) i_conv (.clk(clk), .rst(rst), .conv_req(conv_req),
        .conv_rsp(conv_rsp));

    always #12.5 clk = ~clk;

    // ==========================================================
    // Checking and register access
    task automatic end_of_test();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] ad, input logic [7:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= ad;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] ad, input logic [7:0] exp, input logic [7:0] m = 8'hff);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= ad;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        check({7'h00, reg_rvalid}, 8'h01);
        check(reg_rdata & m, exp);
    endtask

    // Pins settle through synchronisers, so give them ten cycles
    task automatic poke(input bit ch, input logic [6:0] v);
        @(posedge clk);
        if (ch) pins_ch2 <= v;
        else pins_ch1 <= v;
        repeat (10) @(posedge clk);
    endtask

    task automatic ack();
        @(posedge clk);
        alert_ack <= 1'b1;
        @(posedge clk);
        alert_ack <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            end_of_test();
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (8) @(posedge clk);
        rd(8'hd3, 8'h00);
        rd(8'hd7, 8'h00);
        rd(8'he4, 8'h20, 8'hf1);
        wr(8'h00, 8'hff);
        rd(8'h00, 8'h00);
        for (int ch = 0; ch < 2; ch++) begin
            for (int i = 0; i < 6; i++) begin
                flip = (i == 5) ? 7'h60 : 7'(1 << i);
                a = ch[0] ? 8'hd7 : 8'hd3;
                @(posedge clk);
                alert_en_ch1 <= ch[0] ? 6'h00 : 6'(1 << i);
                alert_en_ch2 <= ch[0] ? 6'h3f ^ 6'(1 << i) : 6'h00;
                poke(ch[0], 7'h5a ^ flip);
                rd(a, 8'(1 << i));
                check({7'h00, alert_oe}, ch[0] ? 8'h00 : 8'h01);
                rd(ch[0] ? 8'hd3 : 8'hd7, 8'h00);
                poke(ch[0], 7'h5a);
                rd(a, 8'(1 << i));
                wr(a, 8'hc0);
                rd(a, 8'h00);
                check({7'h00, alert_oe}, 8'h00);
            end
        end
        // Free run has visited every input by now
        for (int i = 0; i < 6; i++) begin
            d = {i[2:0], i[2:0], i[2:0], 1'b1};
            rd(8'hd8 + 8'(2 * i), d[9:2]);
            rd(8'hd9 + 8'(2 * i), {d[1:0], 6'h00});
        end
        wr(8'he4, 8'h01);
        rd(8'he4, 8'h01);
        repeat (LAT + 4) @(posedge clk);
        ack();
        wr(8'he4, 8'hc1);
        rd(8'he4, 8'h21);
        repeat (LAT + 4) @(posedge clk);
        rd(8'he4, 8'h01);
        for (int i = 0; i < 6; i++) begin
            d = {i[2:0], i[2:0], i[2:0], 1'b1};
            a = 8'hd8 + 8'(2 * i);
            wr(a, 8'h00);
            wr(a + 8'h01, 8'hff);
            rd(a + 8'h01, 8'hc0);
            wr(8'he4, 8'h11 | 8'(i << 1));
            wr(8'he4, 8'h11 | 8'(((i + 1) % 6) << 1));
            rd(8'he4, 8'h31 | 8'(i << 1));
            repeat (LAT + 4) @(posedge clk);
            rd(8'he4, 8'h11 | 8'(i << 1));
            rd(a, d[9:2]);
            rd(a + 8'h01, {d[1:0], 6'h00});
            check({7'h00, alert_oe}, 8'h01);
            ack();
            check({7'h00, alert_oe}, 8'h00);
        end
        wr(8'he4, 8'h00);
        rd(8'he4, 8'h20, 8'hf1);
        end_of_test();
    end
endmodule // fla_regs_test
